// ==== rtl/sea_access.sv ====
// sea_access: erase, write and read sequencer for a serial eeprom link
// Summary of operation
// - link framing fixed at external 1x clock, 8 data, 1 stop, no parity
// - select goes high before any command byte of a transfer
// - transfer starts only once transmitter holds no earlier byte
// - every write is preceded by an erase transfer of that word
// - erase byte: low two bits one, high nibble address reversed
// - after erase or write empties, select low then 30 ms wait
// - write sends command then two data bytes, loaded when hold empties
// - write byte: start is leading one, opcode 0100, then A3..A0
// - framing bits between bytes become four unusable stored bits
// - payload twelve bits: byte two to D13..D6, byte three to D3..D0
// - read byte holds read opcode low and reversed address high
// - after read command empties collect two received bytes
// - select output high means the memory is chosen
// - transmit feeds memory input, memory output feeds receive
`timescale 1ns/100ps
module sea_access #(
  parameter int PROG_CYCLES = sea_pkg::PROG_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic memory_serial_clock,
  input wire logic rx_line,
  input wire logic req_valid,
  input sea_pkg::sea_req_type req,
  output logic req_ready,
  output logic done,
  output sea_pkg::sea_rsp_type rsp,
  output logic memory_serial_in,
  output logic memory_select
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [2:0] clk_sync;
    logic [1:0] rx_sync;
    sea_pkg::sea_state_type st;
    sea_pkg::sea_op_type op;
    logic [3:0] addr;
    logic [11:0] data;
    logic erase_phase;
    logic [1:0] idx;
    logic [31:0] timer;
    logic [4:0] rises;
    logic [15:0] word;
    logic ready;
    logic done;
    sea_pkg::sea_rsp_type rsp;
    logic select;
  } sea_state_bundle_type;

  sea_state_bundle_type s_q, s_d;
  logic link_rise;
  logic link_fall;
  logic hold_empty;
  logic shift_empty;
  logic load_valid;
  logic [7:0] load_byte;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] cmd_byte(input logic [3:0] opc,
                                          input logic [3:0] a);
    // address bit 3 sits at byte bit 4
    cmd_byte = {a[0], a[1], a[2], a[3], opc};
  endfunction

  function automatic logic [11:0] unmap_word(input logic [15:0] w);
    logic [11:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = w[sea_pkg::HI_TOP - i];
    end
    for (int j = 0; j < 4; j++) begin
      r[8 + j] = w[sea_pkg::LO_TOP - j];
    end
    unmap_word = r;
  endfunction

  // link edges come from the synchronised copy only
  assign link_rise = s_q.clk_sync[1] && !s_q.clk_sync[2];
  assign link_fall = !s_q.clk_sync[1] && s_q.clk_sync[2];

  // ****************************************************************
  // byte source
  // ****************************************************************
  always_comb begin
    load_byte = '0;
    load_valid = 1'b0;
    if (s_q.st == sea_pkg::ST_SEND && hold_empty) begin
      load_valid = 1'b1;
      if (s_q.erase_phase) begin
        load_byte = cmd_byte(sea_pkg::OPC_ERASE, s_q.addr);
      end else if (s_q.op == sea_pkg::OP_READ) begin
        load_byte = cmd_byte(sea_pkg::OPC_READ, s_q.addr);
      end else begin
        unique case (s_q.idx)
          2'h0: load_byte = cmd_byte(sea_pkg::OPC_WRITE, s_q.addr);
          2'h1: load_byte = s_q.data[7:0];
          default: load_byte = {4'h0, s_q.data[11:8]};
        endcase
      end
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    s_d.clk_sync = {s_q.clk_sync[1:0], memory_serial_clock};
    s_d.rx_sync = {s_q.rx_sync[0], rx_line};
    s_d.done = 1'b0;
    unique case (s_q.st)
      sea_pkg::ST_IDLE: begin
        s_d.ready = 1'b1;
        if (req_valid && s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.op = req.op;
          s_d.addr = req.addr;
          s_d.data = req.data;
          s_d.erase_phase = (req.op != sea_pkg::OP_READ);
          s_d.st = sea_pkg::ST_SEL;
        end
      end
      sea_pkg::ST_SEL: begin
        s_d.select = 1'b1;
        s_d.idx = 2'h0;
        if (shift_empty && s_q.select) begin
          s_d.st = sea_pkg::ST_SEND;
        end
      end
      sea_pkg::ST_SEND: begin
        if (load_valid) begin
          s_d.idx = s_q.idx + 2'h1;
          if (s_q.erase_phase || s_q.op == sea_pkg::OP_READ) begin
            if (s_q.idx + 2'h1 == sea_pkg::BYTES_SHORT) begin
              s_d.st = sea_pkg::ST_DRAIN;
            end
          end else if (s_q.idx + 2'h1 == sea_pkg::BYTES_WRITE) begin
            s_d.st = sea_pkg::ST_DRAIN;
          end
        end
      end
      sea_pkg::ST_DRAIN: begin
        s_d.rises = '0;
        if (shift_empty) begin
          if (!s_q.erase_phase && s_q.op == sea_pkg::OP_READ) begin
            s_d.st = sea_pkg::ST_RECV;
          end else begin
            s_d.select = 1'b0;
            s_d.timer = '0;
            s_d.st = sea_pkg::ST_WAIT;
          end
        end
      end
      sea_pkg::ST_WAIT: begin
        s_d.timer = s_q.timer + 32'h1;
        if (s_q.timer + 32'h1 >= 32'(PROG_CYCLES)) begin
          if (s_q.erase_phase && s_q.op == sea_pkg::OP_WRITE) begin
            s_d.erase_phase = 1'b0;
            s_d.st = sea_pkg::ST_SEL;
          end else begin
            s_d.done = 1'b1;
            s_d.rsp.read = 1'b0;
            s_d.st = sea_pkg::ST_IDLE;
          end
        end
      end
      sea_pkg::ST_RECV: begin
        if (link_rise) begin
          s_d.rises = s_q.rises + 5'h1;
          if (s_q.rises < sea_pkg::RX_WORD_RISES) begin
            s_d.word = {s_q.word[14:0], s_q.rx_sync[1]};
          end
          if (s_q.rises + 5'h1 == sea_pkg::RX_RISES) begin
            s_d.select = 1'b0;
            s_d.done = 1'b1;
            s_d.rsp.read = 1'b1;
            s_d.rsp.data = unmap_word(s_q.word);
            s_d.st = sea_pkg::ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // transmitter
  // ****************************************************************
  sea_tx u_tx (
    .clock(clock),
    .arst_n(arst_n),
    .link_fall(link_fall),
    .load_valid(load_valid),
    .load_byte(load_byte),
    .hold_empty(hold_empty),
    .shift_empty(shift_empty),
    .line(memory_serial_in)
  );

  assign req_ready = s_q.ready;
  assign done = s_q.done;
  assign rsp = s_q.rsp;
  assign memory_select = s_q.select;

endmodule

// ==== rtl/sea_pkg.sv ====
// sea_pkg: constants and types for the serial eeprom access sequencer
package sea_pkg;

  // ****************************************************************
  // link framing
  // ****************************************************************
  localparam int DATA_BITS = 8;
  localparam int STOP_BITS = 1;
  localparam int PARITY_EN = 0;
  localparam int FRAME_BITS = 1 + DATA_BITS + PARITY_EN + STOP_BITS;
  localparam logic [3:0] FRAME_LAST = 4'(FRAME_BITS - 1);
  // level the memory input sees for each framing bit and when idle
  localparam logic START_LEVEL = 1'b1;
  localparam logic STOP_LEVEL = 1'b0;
  localparam logic IDLE_LEVEL = 1'b0;

  // ****************************************************************
  // commands
  // ****************************************************************
  localparam logic [3:0] OPC_ERASE = 4'h3;
  localparam logic [3:0] OPC_WRITE = 4'h2;
  localparam logic [3:0] OPC_READ = 4'h1;
  localparam int ADDR_W = 4;
  localparam int PAYLOAD_W = 12;
  localparam int WORD_W = 16;
  localparam logic [1:0] BYTES_SHORT = 2'h1;
  localparam logic [1:0] BYTES_WRITE = 2'h3;
  // rising link edges watched after the read command empties
  localparam logic [4:0] RX_RISES = 5'h13;
  localparam logic [4:0] RX_WORD_RISES = 5'h10;
  // stored bit positions of the usable payload
  localparam int HI_TOP = 13;
  localparam int LO_TOP = 3;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int PROG_TIME_MS = 30;
  localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_ERASE = 2'h1,
    OP_WRITE = 2'h2
  } sea_op_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SEL = 3'h1,
    ST_SEND = 3'h3,
    ST_DRAIN = 3'h2,
    ST_WAIT = 3'h6,
    ST_RECV = 3'h7
  } sea_state_type;

  typedef struct packed {
    sea_op_type op;
    logic [ADDR_W-1:0] addr;
    logic [PAYLOAD_W-1:0] data;
  } sea_req_type;

  typedef struct packed {
    logic [PAYLOAD_W-1:0] data;
    logic read;
  } sea_rsp_type;

endpackage

// ==== rtl/sea_tx.sv ====
// sea_tx: transmit holding register and frame shifter on link edges
`timescale 1ns/100ps
module sea_tx (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic link_fall,
  input wire logic load_valid,
  input wire logic [7:0] load_byte,
  output logic hold_empty,
  output logic shift_empty,
  output logic line
);

  typedef struct packed {
    logic [9:0] shift;
    logic [3:0] cnt;
    logic [7:0] hold;
    logic hold_full;
    logic active;
    logic line;
  } sea_tx_state_type;

  sea_tx_state_type s_q, s_d;

  assign hold_empty = !s_q.hold_full;
  assign shift_empty = !s_q.active && !s_q.hold_full;
  assign line = s_q.line;

  always_comb begin
    s_d = s_q;
    if (link_fall) begin
      if (s_q.cnt != 4'h0) begin
        s_d.line = s_q.shift[0];
        s_d.shift = {1'b0, s_q.shift[9:1]};
        s_d.cnt = s_q.cnt - 4'h1;
      end else if (s_q.hold_full) begin
        // one start, eight data, one stop, no parity
        s_d.line = sea_pkg::START_LEVEL;
        s_d.shift = {1'b0, sea_pkg::STOP_LEVEL, s_q.hold};
        s_d.cnt = sea_pkg::FRAME_LAST;
        s_d.hold_full = 1'b0;
        s_d.active = 1'b1;
      end else begin
        s_d.line = sea_pkg::IDLE_LEVEL;
        s_d.active = 1'b0;
      end
    end
    if (load_valid && !s_q.hold_full) begin
      s_d.hold = load_byte;
      s_d.hold_full = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// ==== dv/sea_access_asserts.sv ====
// sea_access_asserts: timing checks on the access sequencer ports
`timescale 1ns/100ps
module sea_access_asserts #(
  parameter int PROG_CYCLES = sea_pkg::PROG_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic memory_serial_clock,
  input wire logic req_valid,
  input sea_pkg::sea_req_type req,
  input wire logic req_ready,
  input wire logic done,
  input sea_pkg::sea_rsp_type rsp,
  input wire logic memory_serial_in,
  input wire logic memory_select
);
  // ****
  // helpers: cycles deselected, cycles since link fall, op kind
  // ****
  logic [31:0] low_q;
  logic [3:0] age_q;
  logic prog_q;
  logic kind_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      low_q <= 32'h0;
      age_q <= 4'hF;
      prog_q <= 1'b0;
      kind_q <= 1'b0;
    end else begin
      low_q <= memory_select ? 32'h0 : low_q + 32'(low_q != 32'hFFFFFFFF);
      age_q <= $fell(memory_serial_clock) ? 4'h0 : age_q + 4'(age_q != 4'hF);
      if ($fell(memory_select)) prog_q <= kind_q;
      if (req_valid && req_ready) kind_q <= req.op != sea_pkg::OP_READ;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ****
  // assertions
  // ****
  a_select_leads_tx: assert property (
    $rose(memory_serial_in) |-> memory_select)
    else $error("tx line rose while memory not selected");
  a_line_idle_low: assert property (
    !memory_select |-> !memory_serial_in)
    else $error("tx line high while deselected");
  a_prog_wait_held: assert property (
    $rose(memory_select) && prog_q |-> low_q >= 32'(PROG_CYCLES))
    else $error("select raised before programming time ran out");
  a_tx_after_fall: assert property (
    $changed(memory_serial_in) |-> age_q < 4'h6)
    else $error("tx line changed away from a link falling edge");
  a_done_one_pulse: assert property (
    done |-> !req_ready ##1 (req_ready && !done))
    else $error("done not a single pulse before ready");
  a_rsp_on_done: assert property (
    $changed(rsp) |-> done)
    else $error("response changed without done");
  a_idle_deselect: assert property (
    req_ready |-> !memory_select)
    else $error("memory selected while idle");
  a_done_kind_flag: assert property (
    done |-> rsp.read == !kind_q)
    else $error("read flag does not match operation");
endmodule
bind sea_access sea_access_asserts #(.PROG_CYCLES(PROG_CYCLES)) chk (
  .clock(clock), .arst_n(arst_n), .memory_serial_clock(memory_serial_clock),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .done(done),
  .rsp(rsp), .memory_serial_in(memory_serial_in),
  .memory_select(memory_select));

// ==== dv/sea_mem_model.sv ====
// sea_mem_model: behavioural serial memory of sixteen 16-bit words
`timescale 1ns/100ps
module sea_mem_model #(
  parameter int PROG_NS = 5000
) (
  input wire logic mem_clock,
  input wire logic cs,
  input wire logic din,
  output logic dout
);
  logic [15:0] mem [16];
  logic [15:0] sr = 16'h0;
  logic [1:0] op = 2'h0;
  logic [3:0] adr = 4'h0;
  logic run = 1'b0;
  logic pend = 1'b0;
  int cnt = 0;
  int viol = 0;
  realtime busy_until = 0;
  initial begin
    dout = 1'b0;
    for (int k = 0; k < 16; k++) mem[k] = 16'h0;
  end
  always @(posedge cs) if ($realtime < busy_until) viol++;
  always @(negedge cs) begin
    if (pend && op == 2'h3) mem[adr] = 16'hFFFF;
    if (pend && op == 2'h1) begin
      if (mem[adr] !== 16'hFFFF) viol++;
      mem[adr] = sr;
    end
    if (pend) busy_until = $realtime + PROG_NS;
    run = 1'b0;
    pend = 1'b0;
    op = 2'h0;
  end
  // ****
  // shift in on rising link edges, leading one opens a command
  // ****
  always @(posedge mem_clock) if (cs) begin
    if (!run) begin
      run = din;
      cnt = 0;
    end else begin
      cnt++;
      if (cnt <= 24) sr = {sr[14:0], din};
      if (cnt == 8) {op, adr} = {sr[7:6], sr[3:0]};
      if (cnt == 8 && op == 2'h3 || cnt == 24 && op == 2'h1) pend = 1'b1;
    end
  end
  // undriven output shows a changing level
  always @(negedge mem_clock)
    if (cs && op == 2'h2 && cnt >= 9 && cnt <= 24)
      dout <= mem[adr][24-cnt];
    else
      dout <= ~dout;
endmodule

// ==== dv/sea_access_bench.sv ====
// sea_access_bench: random and corner tests of the access sequencer
`timescale 1ns/100ps
module sea_access_bench;
  localparam int PROG = 50;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic link_clk = 1'b0;
  logic req_valid = 1'b0;
  sea_pkg::sea_req_type req = '0;
  logic req_ready, done, memory_serial_in, memory_select, rx_line;
  sea_pkg::sea_rsp_type rsp;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h1E53;
  always #50 clock = ~clock;
  initial begin
    #37;
    forever #400 link_clk = ~link_clk;
  end
  sea_access #(.PROG_CYCLES(PROG)) dut (.clock(clock), .arst_n(arst_n),
    .memory_serial_clock(link_clk), .rx_line(rx_line), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .done(done), .rsp(rsp),
    .memory_serial_in(memory_serial_in), .memory_select(memory_select));
  sea_mem_model #(.PROG_NS(PROG * 100)) mdl (.mem_clock(link_clk),
    .cs(memory_select), .din(memory_serial_in), .dout(rx_line));
  // ****
  // helpers
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [15:0] stored(input logic [11:0] d);
    logic [15:0] w;
    w = 16'h4010; // framing bits land at D15, D14, D5, D4
    for (int i = 0; i < 8; i++) w[13-i] = d[i];
    for (int j = 0; j < 4; j++) w[3-j] = d[8+j];
    return w;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic run(input sea_pkg::sea_op_type op, input logic [3:0] a,
      input logic [11:0] d);
    int n;
    @(negedge clock);
    while (req_ready !== 1'b1) @(negedge clock);
    req_valid = 1'b1;
    req.op = op;
    req.addr = a;
    req.data = d;
    @(negedge clock);
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    if (n == 3000) check(16'h0, 16'h1);
  endtask
  // ****
  // main sequence
  // ****
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      $display("unexpected at %0t: run too long", $time);
      end_of_test();
    end
  end
  initial begin
    logic [3:0] a;
    logic [11:0] d;
    repeat (12) @(negedge clock);
    arst_n = 1'b1;
    for (int t = 0; t < 10; t++) begin
      seed = xs(seed);
      a = (t < 2) ? 4'(t * 15) : seed[3:0];
      d = (t == 0) ? 12'h000 : (t == 1) ? 12'hFFF : seed[15:4];
      run(sea_pkg::OP_WRITE, a, d);
      check(mdl.mem[a], stored(d));
      check(16'(rsp.read), 16'h0);
      run(sea_pkg::OP_READ, a, seed[27:16]);
      check({4'h0, rsp.data}, {4'h0, d});
      check(16'(rsp.read), 16'h1);
      if (t % 3 == 2) begin
        run(sea_pkg::OP_ERASE, a, d);
        check(mdl.mem[a], 16'hFFFF);
        run(sea_pkg::OP_READ, a, d);
        check({4'h0, rsp.data}, 16'h0FFF);
      end
      $display("test %0d done", t);
    end
    check(16'(mdl.viol), 16'h0);
    end_of_test();
  end
endmodule
